// [ccdn_top.sv]
// clock distribution network: primary, secondary, slice and edge clock selection
`timescale 1ns/1ns
module ccdn_top #(
  parameter int NPLL = 10,
  parameter int NROUTE = 4,
  parameter int NXCVR = 4,
  parameter int NREG = 20,
  parameter int PLL_TL = 0,
  parameter int PLL_TR = 1,
  parameter int PLL_L = 2,
  parameter int PLL_R = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asynchronous clock sources
  input wire logic [NPLL-1:0] pllClk,
  input wire logic [1:0] dllClk,
  input wire logic [1:0] slaveDelayClk,
  input wire logic [ccdn_pkg::PADS-1:0] padClk,
  input wire logic [NROUTE-1:0] routeClk,
  input wire logic [NXCVR-1:0] xcvrClk,
  // fabric configuration
  input wire ccdn_pkg::ccdn_quad_cfg_s [ccdn_pkg::QUADS-1:0] quadCfg,
  input wire logic [NREG-1:0][ccdn_pkg::SEC-1:0][ccdn_pkg::SEC_SEL_W-1:0] secSel,
  input wire logic [NREG-1:0][2:0] wideSel,
  input wire logic [NREG-1:0][1:0] narrowSel,
  input wire ccdn_pkg::ccdn_slice_cfg_s [NREG-1:0][ccdn_pkg::SLICES_WITH_REGS-1:0] sliceCfg,
  input wire logic [ccdn_pkg::EDGES-1:0][ccdn_pkg::EDGE_SEL_W-1:0] edgeSel,
  input wire ccdn_pkg::ccdn_div_cfg_s [ccdn_pkg::DIVS-1:0] divCfg,
  // distributed clocks
  output logic [ccdn_pkg::QUADS-1:0][ccdn_pkg::LINES-1:0] primLine,
  output logic [NREG-1:0][ccdn_pkg::SEC-1:0] secLine,
  output logic [NREG-1:0] wideSw,
  output logic [NREG-1:0] narrowSw,
  output logic [NREG-1:0][ccdn_pkg::SLICES_WITH_REGS-1:0] sliceClk,
  output logic [NREG-1:0][ccdn_pkg::SLICES_WITH_REGS-1:0] sliceCtl,
  output logic [ccdn_pkg::EDGES-1:0] edgeClk,
  output logic [ccdn_pkg::DIVS-1:0] divClk
);
  import ccdn_pkg::*;

  localparam int AW = NPLL + 2 + 2 + PADS + NROUTE + NXCVR;
  localparam int NSRC = NPLL + 2 + DIVS + PADS + NROUTE + NXCVR;
  localparam int NSECSRC = PADS + EDGES + NROUTE;

  // two-stage synchronisers; clock inputs are treated as sampled levels
  // limitation: a source level shorter than one clk period may be missed entirely
  logic [AW-1:0] sync1_ff;
  logic [AW-1:0] sync2_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {xcvrClk, routeClk, padClk, slaveDelayClk, dllClk, pllClk};
      sync2_ff <= sync1_ff;
    end
  end

  logic [NPLL-1:0] pllS;
  logic [1:0] dllS;
  logic [1:0] sdlS;
  logic [PADS-1:0] padS;
  logic [NROUTE-1:0] routeS;
  logic [NXCVR-1:0] xcvrS;

  // split the synchronised vector by source type
  assign pllS = sync2_ff[NPLL-1:0];
  assign dllS = sync2_ff[NPLL+1:NPLL];
  assign sdlS = sync2_ff[NPLL+3:NPLL+2];
  assign padS = sync2_ff[NPLL+4+PADS-1:NPLL+4];
  assign routeS = sync2_ff[NPLL+4+PADS+NROUTE-1:NPLL+4+PADS];
  assign xcvrS = sync2_ff[AW-1:AW-NXCVR];

  logic [DIVS-1:0] divClk_ff;
  logic [NSRC-1:0] primPool;

  assign primPool = {xcvrS, routeS, padS, divClk_ff, dllS, pllS};

  // ---------------- edge clocks ----------------
  logic [EDGES-1:0] edgeClk_ff;
  logic [EDGES-1:0] edgeNext;

  genvar e;
  generate
    for (e = 0; e < EDGES; e++) begin : g_edge
      localparam int SIDE = e / 2;
      localparam bit IS_TOP = (SIDE == 0);
      localparam int PLLA = IS_TOP ? PLL_TL : (SIDE == 1 ? PLL_L : PLL_R);
      logic pad0;
      logic pad1;
      logic dll0;
      logic dll1;
      logic pllB;
      logic sdl0;
      logic sdl1;
      assign pad0 = padS[2 * SIDE];
      assign pad1 = padS[2 * SIDE + 1];
      assign dll0 = (IS_TOP || SIDE == 1) ? dllS[0] : 1'b0;
      assign dll1 = (IS_TOP || SIDE == 2) ? dllS[1] : 1'b0;
      // top sees the far corner pll too
      assign pllB = IS_TOP ? pllS[PLL_TR] : 1'b0;
      assign sdl0 = IS_TOP ? 1'b0 : sdlS[0];
      assign sdl1 = IS_TOP ? 1'b0 : sdlS[1];
      assign edgeNext[e] =
        (edgeSel[e] == EDGE_PAD0) ? pad0 :
        (edgeSel[e] == EDGE_PAD1) ? pad1 :
        (edgeSel[e] == EDGE_DLL0) ? dll0 :
        (edgeSel[e] == EDGE_DLL1) ? dll1 :
        (edgeSel[e] == EDGE_PLLA) ? pllS[PLLA] :
        (edgeSel[e] == EDGE_PLLB) ? pllB :
        (edgeSel[e] == EDGE_SDL0) ? sdl0 : sdl1;
    end
  endgenerate

  // edge clock registers
  always_ff @(posedge clk) begin
    if (rst) begin
      edgeClk_ff <= '0;
    end else begin
      edgeClk_ff <= edgeNext;
    end
  end

  // ---------------- edge clock dividers ----------------
  logic [DIVS-1:0] divPrev_ff;
  logic [DIVS-1:0] divRun_ff;
  logic [DIVS-1:0][2:0] divCnt_ff;
  logic [DIVS-1:0] nxt_divRun;
  logic [DIVS-1:0][2:0] nxt_divCnt;
  logic [DIVS-1:0] nxt_divClk;

  // side edge clock 0 drives each divider
  genvar d;
  generate
    for (d = 0; d < DIVS; d++) begin : g_div
      localparam int SRC = 2 + 2 * d;
      logic rise;
      assign rise = edgeClk_ff[SRC] && !divPrev_ff[d];
      // release only on an input rising edge so phase is known
      assign nxt_divRun[d] = divCfg[d].rstDiv ? 1'b0 :
                             (divRun_ff[d] || (rise && divCfg[d].relEn));
      assign nxt_divCnt[d] = divCfg[d].rstDiv ? DIV_CNT_RST :
                             (!divRun_ff[d] && nxt_divRun[d]) ? DIV_CNT_REL :
                             (divRun_ff[d] && rise) ? 3'(divCnt_ff[d] + 3'h1) :
                             divCnt_ff[d];
      assign nxt_divClk[d] = nxt_divRun[d] && nxt_divCnt[d][divCfg[d].mode];
    end
  endgenerate

  // divider state; reset forces outputs low at once
  always_ff @(posedge clk) begin
    if (rst) begin
      divPrev_ff <= '0;
      divRun_ff <= '0;
      divCnt_ff <= '0;
      divClk_ff <= '0;
    end else begin
      divPrev_ff <= {edgeClk_ff[4], edgeClk_ff[2]};
      divRun_ff <= nxt_divRun;
      divCnt_ff <= nxt_divCnt;
      divClk_ff <= nxt_divClk;
    end
  end

  // ---------------- primary quadrant network ----------------
  logic [QUADS-1:0][LINES-1:0] preGate;
  logic [QUADS-1:0][LINES-1:0] gateEn_ff;
  logic [QUADS-1:0][LINES-1:0] nxt_gateEn;
  logic [QUADS-1:0][LINES-1:0] primLine_ff;

  genvar q;
  genvar l;
  generate
    for (q = 0; q < QUADS; q++) begin : g_quad
      for (l = 0; l < CEN_LINES; l++) begin : g_cen
        assign preGate[q][l] = (int'(quadCfg[q].primSel[l]) < NSRC) ?
                               primPool[quadCfg[q].primSel[l]] : 1'b0;
      end
      // two selectors on lines 6, 7
      for (l = 0; l < GSEL_PER_Q; l++) begin : g_gsel
        logic inA;
        logic inB;
        assign inA = (int'(quadCfg[q].gselSrcA[l]) < NSRC) ?
                     primPool[quadCfg[q].gselSrcA[l]] : 1'b0;
        assign inB = (int'(quadCfg[q].gselSrcB[l]) < NSRC) ?
                     primPool[quadCfg[q].gselSrcB[l]] : 1'b0;
        ccdn_glitchless_sel u_sel (
          .clk(clk),
          .rst(rst),
          .clkA(inA),
          .clkB(inB),
          .pick(quadCfg[q].gselPick[l]),
          .outClk(preGate[q][CEN_LINES + l])
        );
      end
      // holding the old enable through a high phase keeps every pulse whole
      for (l = 0; l < LINES; l++) begin : g_gate
        assign nxt_gateEn[q][l] = preGate[q][l] ? gateEn_ff[q][l] : quadCfg[q].gateEn;
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      gateEn_ff <= {(QUADS * LINES){GATE_EN_RST}};
      primLine_ff <= '0;
    end else begin
      gateEn_ff <= nxt_gateEn;
      primLine_ff <= preGate & nxt_gateEn;
    end
  end

  // ---------------- secondary network ----------------
  logic [NSECSRC-1:0] secPool;
  logic [NREG-1:0][SEC-1:0] secLine_ff;
  logic [NREG-1:0][SEC-1:0] secNext;
  logic [NREG-1:0] wideSw_ff;
  logic [NREG-1:0] narrowSw_ff;

  assign secPool = {routeS, edgeClk_ff, padS};

  genvar r;
  genvar i;
  generate
    for (r = 0; r < NREG; r++) begin : g_secmux
      for (i = 0; i < SEC; i++) begin : g_line
        assign secNext[r][i] = (int'(secSel[r][i]) < NSECSRC) ?
                               secPool[secSel[r][i]] : 1'b0;
      end
    end
  endgenerate

  // secondary lines and lut input switches
  always_ff @(posedge clk) begin
    if (rst) begin
      secLine_ff <= '0;
      wideSw_ff <= '0;
      narrowSw_ff <= '0;
    end else begin
      secLine_ff <= secNext;
      for (int k = 0; k < NREG; k++) begin
        wideSw_ff[k] <= secLine_ff[k][wideSel[k]];
        narrowSw_ff[k] <= secLine_ff[k][{1'b1, narrowSel[k]}];
      end
    end
  end

  // ---------------- slice clock and control muxes ----------------
  // regions are spread round-robin over the quadrants
  logic [NREG-1:0][SLICES_WITH_REGS-1:0] sliceClkNext;
  logic [NREG-1:0][SLICES_WITH_REGS-1:0] sliceCtlNext;
  logic [NREG-1:0][SLICES_WITH_REGS-1:0] sliceClk_ff;
  logic [NREG-1:0][SLICES_WITH_REGS-1:0] sliceCtl_ff;

  genvar s;
  generate
    for (r = 0; r < NREG; r++) begin : g_slice
      logic [6:0] secClkSet;
      logic [4:0] secCtlSet;
      assign secClkSet = {secLine_ff[r][7:4], secLine_ff[r][2:0]};
      assign secCtlSet = {secLine_ff[r][7], secLine_ff[r][3:0]};
      for (s = 0; s < SLICES_WITH_REGS; s++) begin : g_s
        logic [3:0] cs;
        logic [2:0] ts;
        assign cs = sliceCfg[r][s].clkSel;
        assign ts = sliceCfg[r][s].ctlSel;
        assign sliceClkNext[r][s] =
          (cs < SCLK_SEC_BASE) ? primLine_ff[r % QUADS][cs[2:0]] :
          (cs == SCLK_NONE) ? 1'b1 : secClkSet[3'(cs - SCLK_SEC_BASE)];
        assign sliceCtlNext[r][s] =
          (ts <= SCTL_SEC7) ? secCtlSet[ts] :
          (ts == SCTL_NARROW) ? narrowSw_ff[r] : 1'b1;
      end
    end
  endgenerate

  // slice mux outputs; reset shows the idle value of one
  always_ff @(posedge clk) begin
    if (rst) begin
      sliceClk_ff <= '1;
      sliceCtl_ff <= '1;
    end else begin
      sliceClk_ff <= sliceClkNext;
      sliceCtl_ff <= sliceCtlNext;
    end
  end

  // outputs straight from their registers
  // trade-off: one flop per mux stage adds latency but gives clean output levels
  assign primLine = primLine_ff;
  assign secLine = secLine_ff;
  assign wideSw = wideSw_ff;
  assign narrowSw = narrowSw_ff;
  assign sliceClk = sliceClk_ff;
  assign sliceCtl = sliceCtl_ff;
  assign edgeClk = edgeClk_ff;
  assign divClk = divClk_ff;
endmodule

// [ccdn_pkg.sv]
// shared constants, codes and config structs for the clock distribution network
package ccdn_pkg;
  // fabric shape
  localparam int QUADS = 4;
  localparam int LINES = 8;
  localparam int GSEL_PER_Q = 2;
  localparam int CEN_LINES = LINES - GSEL_PER_Q;
  localparam int PADS = 6;
  localparam int EDGES = 6;
  localparam int SEC = 8;
  localparam int SLICES_WITH_REGS = 3;
  localparam int DIVS = 2;
  // select widths
  localparam int SRC_SEL_W = 5;
  localparam int SEC_SEL_W = 4;
  localparam int EDGE_SEL_W = 3;
  // slice clock select codes: 0..7 primary line, 8..14 secondary, 15 none
  localparam logic [3:0] SCLK_SEC_BASE = 4'h8;
  localparam logic [3:0] SCLK_NONE = 4'hF;
  // slice control select codes: 0..3 secondary 0..3
  localparam logic [2:0] SCTL_SEC7 = 3'h4;
  localparam logic [2:0] SCTL_NARROW = 3'h5;
  // edge clock source codes
  localparam logic [2:0] EDGE_PAD0 = 3'h0;
  localparam logic [2:0] EDGE_PAD1 = 3'h1;
  localparam logic [2:0] EDGE_DLL0 = 3'h2;
  localparam logic [2:0] EDGE_DLL1 = 3'h3;
  localparam logic [2:0] EDGE_PLLA = 3'h4;
  localparam logic [2:0] EDGE_PLLB = 3'h5;
  localparam logic [2:0] EDGE_SDL0 = 3'h6;
  localparam logic [2:0] EDGE_SDL1 = 3'h7;
  // reset and release values
  localparam logic [2:0] DIV_CNT_RST = 3'h0;
  localparam logic [2:0] DIV_CNT_REL = 3'h1;
  localparam logic GSEL_PICK_RST = 1'b0;
  localparam logic GATE_EN_RST = 1'b1;

  typedef enum logic [1:0] {
    DIV_BY2 = 2'h0,
    DIV_BY4 = 2'h1,
    DIV_BY8 = 2'h2
  } ccdn_div_e;

  typedef enum logic [1:0] {
    GSEL_RUN = 2'b01,
    GSEL_SWAP = 2'b10
  } ccdn_gsel_e;

  typedef struct packed {
    logic gateEn;
    logic [GSEL_PER_Q-1:0] gselPick;
    logic [GSEL_PER_Q-1:0][SRC_SEL_W-1:0] gselSrcB;
    logic [GSEL_PER_Q-1:0][SRC_SEL_W-1:0] gselSrcA;
    logic [CEN_LINES-1:0][SRC_SEL_W-1:0] primSel;
  } ccdn_quad_cfg_s;

  typedef struct packed {
    logic [3:0] clkSel;
    logic [2:0] ctlSel;
  } ccdn_slice_cfg_s;

  typedef struct packed {
    logic rstDiv;
    logic relEn;
    ccdn_div_e mode;
  } ccdn_div_cfg_s;
endpackage

// [ccdn_glitchless_sel.sv]
// glitch-free two-input clock selector on sampled clock levels
`timescale 1ns/1ns
module ccdn_glitchless_sel (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // candidate clocks and select
  input wire logic clkA,
  input wire logic clkB,
  input wire logic pick,
  // selected clock
  output logic outClk
);
  import ccdn_pkg::*;

  ccdn_gsel_e state_ff;
  ccdn_gsel_e nxt_state;
  logic cur_ff;
  logic nxt_cur;
  logic out_ff;
  logic nxt_out;
  logic oldIn;
  logic newIn;

  assign oldIn = cur_ff ? clkB : clkA;
  assign newIn = pick ? clkB : clkA;
  assign outClk = out_ff;

  // leave the old clock only at its low phase, join the new one only at its low phase
  always_comb begin
    nxt_state = state_ff;
    nxt_cur = cur_ff;
    nxt_out = oldIn;
    case (state_ff)
      GSEL_RUN: begin
        if (pick != cur_ff && !oldIn) begin
          nxt_out = 1'b0;
          nxt_state = GSEL_SWAP;
        end
      end
      GSEL_SWAP: begin
        nxt_out = 1'b0;
        if (!newIn) begin
          nxt_cur = pick;
          nxt_state = GSEL_RUN;
        end
      end
      default: begin
        nxt_state = GSEL_RUN;
        nxt_out = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= GSEL_RUN;
      cur_ff <= GSEL_PICK_RST;
      out_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cur_ff <= nxt_cur;
      out_ff <= nxt_out;
    end
  end
endmodule

// [ccdn_checker.sv]
// port assertions for the clock distribution network
`timescale 1ns/1ns
module ccdn_checker #(
  parameter int NREG = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sources and configuration
  input wire logic [ccdn_pkg::PADS-1:0] padClk,
  input wire ccdn_pkg::ccdn_quad_cfg_s [ccdn_pkg::QUADS-1:0] quadCfg,
  input wire logic [NREG-1:0][1:0] narrowSel,
  input wire ccdn_pkg::ccdn_slice_cfg_s [NREG-1:0][ccdn_pkg::SLICES_WITH_REGS-1:0] sliceCfg,
  input wire logic [ccdn_pkg::EDGES-1:0][ccdn_pkg::EDGE_SEL_W-1:0] edgeSel,
  input wire ccdn_pkg::ccdn_div_cfg_s [ccdn_pkg::DIVS-1:0] divCfg,
  // distributed clocks
  input wire logic [ccdn_pkg::QUADS-1:0][ccdn_pkg::LINES-1:0] primLine,
  input wire logic [NREG-1:0][ccdn_pkg::SEC-1:0] secLine,
  input wire logic [NREG-1:0] narrowSw,
  input wire logic [NREG-1:0][ccdn_pkg::SLICES_WITH_REGS-1:0] sliceClk,
  input wire logic [NREG-1:0][ccdn_pkg::SLICES_WITH_REGS-1:0] sliceCtl,
  input wire logic [ccdn_pkg::EDGES-1:0] edgeClk,
  input wire logic [ccdn_pkg::DIVS-1:0] divClk
);
  import ccdn_pkg::*;
  logic [2:0] upCnt_ff;
  logic up;
  // settle count: synchronisers still hold reset levels just after release
  always_ff @(posedge clk) begin
    if (rst) begin
      upCnt_ff <= 3'h0;
    end else if (!up) begin
      upCnt_ff <= upCnt_ff + 3'h1;
    end
  end
  assign up = (upCnt_ff == 3'h7);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_edge_pad_path: assert property (up && $past(edgeSel[4]) == EDGE_PAD1 |->
    edgeClk[4] == $past(padClk[5], 3)) else $error("edge clock not three edges behind pad");
  a_gate_off_still: assert property (up && !quadCfg[1].gateEn &&
    !$past(quadCfg[1].gateEn) && !$past(quadCfg[1].gateEn, 2) |-> !$rose(primLine[1][1]))
    else $error("disabled line rose");
  a_gate_no_runt: assert property (up && $changed(primLine[1][1]) |=>
    $stable(primLine[1][1])) else $error("gated line shortened phase");
  a_sel_no_runt: assert property (up && $changed(primLine[0][6]) |=>
    $stable(primLine[0][6])) else $error("selector line shortened phase");
  a_slice_none_one: assert property (sliceCfg[0][0].clkSel == SCLK_NONE |=>
    sliceClk[0][0]) else $error("unselected slice clock not one");
  a_slice_prim_path: assert property (sliceCfg[0][0].clkSel == 4'h3 |=>
    sliceClk[0][0] == $past(primLine[0][3])) else $error("slice clock not primary line");
  a_ctl_sec_seven: assert property (sliceCfg[0][1].ctlSel == SCTL_SEC7 |=>
    sliceCtl[0][1] == $past(secLine[0][7])) else $error("slice control not secondary");
  a_narrow_sw_path: assert property (narrowSel[0] == 2'h3 |=>
    narrowSw[0] == $past(secLine[0][7])) else $error("narrow switch wrong source");
  a_div_reset_low: assert property (divCfg[0].rstDiv |=> !divClk[0])
    else $error("divider not low in reset");
endmodule
bind ccdn_top ccdn_checker #(.NREG(NREG)) chk (.clk, .rst, .padClk, .quadCfg, .narrowSel,
  .sliceCfg, .edgeSel, .divCfg, .primLine, .secLine, .narrowSw, .sliceClk, .sliceCtl,
  .edgeClk, .divClk);

// [ccdn_src_model.sv]
// clock source model: free-running source clocks at assorted rates
`timescale 1ns/1ns
module ccdn_src_model #(
  parameter int NPLL = 10,
  parameter int NROUTE = 4,
  parameter int NXCVR = 4
) (
  // sampling clock
  input wire logic clk,
  // source clocks
  output logic [NPLL-1:0] pllClk,
  output logic [1:0] dllClk,
  output logic [1:0] slaveDelayClk,
  output logic [5:0] padClk,
  output logic [NROUTE-1:0] routeClk,
  output logic [NXCVR-1:0] xcvrClk
);
  logic [7:0] cnt_ff = 8'h00;
  logic [NPLL+NROUTE+NXCVR+9:0] srcAll;
  // moves on the falling edge so no source ever changes at the sampling edge
  always_ff @(negedge clk) begin
    cnt_ff <= cnt_ff + 8'h01;
  end
  // half periods of two cycles or more, some sources inverted to tell them apart
  always_comb begin
    for (int i = 0; i <= NPLL + NROUTE + NXCVR + 9; i++) begin
      srcAll[i] = cnt_ff[1 + i % 4] ^ i[2];
    end
  end
  assign {xcvrClk, routeClk, padClk, slaveDelayClk, dllClk, pllClk} = srcAll;
endmodule

// [ccdn_top_tb.sv]
// self-checking testbench for the clock distribution network
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module ccdn_top_tb;
  import ccdn_pkg::*;
  localparam int NR = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] pllClk;
  logic [1:0] dllClk, slaveDelayClk;
  logic [5:0] padClk;
  logic [3:0] routeClk, xcvrClk;
  ccdn_quad_cfg_s [QUADS-1:0] quadCfg;
  logic [NR-1:0][SEC-1:0][SEC_SEL_W-1:0] secSel;
  logic [NR-1:0][2:0] wideSel;
  logic [NR-1:0][1:0] narrowSel;
  ccdn_slice_cfg_s [NR-1:0][SLICES_WITH_REGS-1:0] sliceCfg;
  logic [EDGES-1:0][EDGE_SEL_W-1:0] edgeSel;
  ccdn_div_cfg_s [DIVS-1:0] divCfg;
  logic [QUADS-1:0][LINES-1:0] primLine;
  logic [NR-1:0][SEC-1:0] secLine;
  logic [NR-1:0] wideSw, narrowSw;
  logic [NR-1:0][SLICES_WITH_REGS-1:0] sliceClk, sliceCtl;
  logic [EDGES-1:0] edgeClk;
  logic [DIVS-1:0] divClk;
  logic [4:0][27:0] hist;
  int error_cnt = 0;
  int total_checks = 0;

  ccdn_src_model SRC (.clk, .pllClk, .dllClk, .slaveDelayClk, .padClk, .routeClk, .xcvrClk);
  ccdn_top #(.NREG(NR)) DUT (.clk, .rst, .pllClk, .dllClk, .slaveDelayClk, .padClk,
    .routeClk, .xcvrClk, .quadCfg, .secSel, .wideSel, .narrowSel, .sliceCfg, .edgeSel,
    .divCfg, .primLine, .secLine, .wideSw, .narrowSw, .sliceClk, .sliceCtl, .edgeClk, .divClk);

  // 50 MHz clock; source history in primary pool order, newest first
  always #10 clk = ~clk;
  always @(posedge clk) begin
    hist <= {hist[3:0], xcvrClk, routeClk, padClk, slaveDelayClk, dllClk, pllClk};
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic t_reset();
    rst = 1'b1;
    cyc(16);
    `CHK("rstPrim", '0, primLine)
    `CHK("rstSlice", {NR*3{1'b1}}, sliceClk)
    `CHK("rstCtl", {NR*3{1'b1}}, sliceCtl)
    `CHK("rstEdge", '0, edgeClk)
    rst = 1'b0;
  endtask

  // each source kind except the dividers routed to line 0 of every quadrant
  task automatic t_primary();
    int idx[5] = '{0, 10, 14, 20, 25};
    foreach (idx[k]) begin
      for (int q = 0; q < QUADS; q++) begin
        quadCfg[q].primSel[0] = 5'(idx[k]);
      end
      cyc(4);
      repeat (6) begin
        cyc(1);
        for (int q = 0; q < QUADS; q++) begin
          `CHK("primLine", hist[2][idx[k]], primLine[q][0])
        end
      end
    end
  endtask

  // edge mux codes on each side
  task automatic t_edge();
    int e[8] = '{0, 0, 0, 1, 1, 2, 3, 5};
    int c[8] = '{EDGE_PAD0, EDGE_DLL0, EDGE_DLL1, EDGE_PLLA, EDGE_PLLB, EDGE_SDL0, EDGE_PAD1,
      EDGE_SDL1};
    int s[8] = '{14, 10, 11, 0, 1, 12, 17, 13};
    foreach (e[k]) begin
      edgeSel[e[k]] = 3'(c[k]);
      cyc(4);
      repeat (6) begin
        cyc(1);
        `CHK("edgeClk", hist[2][s[k]], edgeClk[e[k]])
      end
    end
  endtask

  // quadrant 1 switched off and on again
  task automatic t_gate();
    quadCfg[1].gateEn = 1'b0;
    cyc(24);
    repeat (16) begin
      cyc(1);
      `CHK("gatedLine", 1'b0, primLine[1][1])
      `CHK("liveLine", hist[2][0], primLine[0][1])
    end
    quadCfg[1].gateEn = 1'b1;
    cyc(40);
    repeat (8) begin
      cyc(1);
      `CHK("regatedLine", hist[2][0], primLine[1][1])
    end
  endtask

  // selector on line 6 swaps fast and slow sources
  task automatic t_select();
    int want[2] = '{11, 0};
    quadCfg[0].gselSrcA[0] = 5'h00;
    quadCfg[0].gselSrcB[0] = 5'h0B;
    foreach (want[k]) begin
      quadCfg[0].gselPick[0] = (k == 0);
      cyc(40);
      repeat (8) begin
        cyc(1);
        `CHK("selLine", hist[3][want[k]], primLine[0][6])
      end
    end
  endtask

  // nothing selected gives one on three slices per region
  task automatic t_slice();
    for (int r = 0; r < NR; r++) begin
      for (int j = 0; j < 3; j++) begin
        sliceCfg[r][j] = '{SCLK_NONE, 3'h6};
      end
    end
    cyc(2);
    `CHK("sliceClk", {NR*3{1'b1}}, sliceClk)
    `CHK("sliceCtl", {NR*3{1'b1}}, sliceCtl)
    `CHK("sliceCount", 3, $bits(DUT.sliceClk[0]))
    for (int r = 0; r < NR; r++) begin
      for (int j = 0; j < 3; j++) begin
        sliceCfg[r][j] = '{4'h3, 3'h6};
      end
    end
    sliceCfg[0][1] = '{4'h8, SCTL_SEC7};
    // region 1: all secondaries from routing 0; slice 1 takes secondary 7, slice 2 narrow
    secSel[1] = {SEC{4'hC}};
    sliceCfg[1][1] = '{4'hE, 3'h6};
    sliceCfg[1][2] = '{SCLK_NONE, SCTL_NARROW};
    cyc(6);
    repeat (6) begin
      cyc(1);
      `CHK("secLine", hist[2][20], secLine[1][0])
      `CHK("wideSw", hist[3][20], wideSw[1])
      `CHK("narrowSw", hist[3][20], narrowSw[1])
      `CHK("sliceSecClk", hist[3][20], sliceClk[1][1])
      `CHK("sliceNarrow", hist[4][20], sliceCtl[1][2])
    end
  endtask

  // divider held low in reset, then divides the left edge clock
  task automatic t_div();
    int rises;
    int pRises;
    logic last;
    logic lastP;
    // divider 0 also routed onto primary line 2 of quadrant 2
    quadCfg[2].primSel[2] = 5'h0C;
    for (int m = 0; m < 3; m++) begin
      divCfg[0] = '{1'b1, 1'b0, ccdn_div_e'(m)};
      cyc(2);
      `CHK("divHeld", 1'b0, divClk[0])
      divCfg[0].rstDiv = 1'b0;
      divCfg[0].relEn = 1'b1;
      // one edge rise only, so the phase is fixed once
      cyc(4);
      divCfg[0].relEn = 1'b0;
      rises = 0;
      pRises = 0;
      last = divClk[0];
      lastP = primLine[2][2];
      repeat (64) begin
        cyc(1);
        rises += (divClk[0] === 1'b1 && last === 1'b0) ? 1 : 0;
        pRises += (primLine[2][2] === 1'b1 && lastP === 1'b0) ? 1 : 0;
        last = divClk[0];
        lastP = primLine[2][2];
      end
      `CHK("divRises", 64 / (8 << m), rises)
      `CHK("divPrimRises", 64 / (8 << m), pRises)
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // main sequence; a second reset mid-run proves recovery
  initial begin
    quadCfg = '0;
    for (int q = 0; q < QUADS; q++) begin
      quadCfg[q].gateEn = 1'b1;
    end
    secSel = '0;
    secSel[0][7] = 4'h6;
    wideSel = '0;
    narrowSel = {NR{2'h3}};
    sliceCfg = '0;
    edgeSel = '0;
    edgeSel[2] = EDGE_SDL0;
    edgeSel[4] = EDGE_PAD1;
    divCfg = '0;
    t_reset();
    t_primary();
    t_edge();
    t_gate();
    t_select();
    t_slice();
    t_div();
    t_reset();
    t_primary();
    report_and_stop();
  end

  // watchdog well beyond the expected run of about six hundred cycles
  initial begin
    #(20 * 5000);
    error_cnt++;
    report_and_stop();
  end
endmodule
